// *** rtl/t4c_pkg.sv ***
// Purpose: constants, register map and field layouts of the timer 4 channel block
// Assumes: 8-bit register port, 20 MHz clock, timer tick from the same clock domain
// Notes:   used by the block top only; its helper synchroniser does not import it
// Summary of operation
// R1 - chan1_control mode bit: 0 selects capture, 1 selects compare; resets to capture
// R2 - edge_sense_select: 00 off, 01 rising, 10 falling, 11 both edges
// R3 - on channel 1 match: action 000 sets, 001 clears, 010 toggles; 111 unused
// R4 - action 011: set on up match, clear at zero, or on down match
// R5 - action 100: clear on up match, set at zero, or on down match
// R6 - action 101: set on own match, clear on channel 0 match
// R7 - action 110: clear on own match, set on channel 0 match
// R8 - chan_irq_enable bit 6 resets to 1; bit 7 reads zero
// R9 - chan0_match_value is 8-bit read/write, resets zero, compare and top count value
// R10 - chan1_match_value is 8-bit read/write, resets zero, compare or captured count
// R11 - flag bank bits 5 and 4 are timer 4 channel flags, cleared writing 0
// R12 - flag bank bit 3 is timer 4 wrap flag, cleared writing 0, resets 0
// R13 - flag bank bits 2..0 are timer 3 channel 1, channel 0, wrap flags
// R14 - flag bank bit 6 is timer 1 wrap enable, resets 1; bit 7 reads zero
// R15 - modulo and up/down modes use chan0_match_value as top count
// R16 - capture edge copies counter into chan1 value and sets channel pending flag in the same cycle
// R17 - channel interrupt only while pending flag and its enable are both set
package t4c_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;

    // register addresses
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h_e9;
    localparam logic [7:0] ADDR_COUNT      = 8'h_ea;
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'h_eb;
    localparam logic [7:0] ADDR_FLAG_BANK  = 8'h_d8;
    localparam logic [7:0] ADDR_CHAN0_VAL  = 8'h_ed;
    localparam logic [7:0] ADDR_CHAN1_CTRL = 8'h_ee;
    localparam logic [7:0] ADDR_CHAN1_VAL  = 8'h_ef;

    // reset values and counter constants
    localparam logic [7:0] VAL_RESET       = 8'h_00;
    localparam logic [7:0] COUNT_ZERO      = 8'h_00;
    localparam logic [7:0] COUNT_FULL      = 8'h_ff;
    localparam logic [7:0] COUNT_ONE       = 8'h_01;
    localparam logic [7:0] READ_ZERO       = 8'h_00;
    localparam logic [5:0] MASK_RESET      = 6'h_3f;

    // timer_control field positions
    localparam int unsigned TC_START_BIT = 4;
    localparam int unsigned TC_CLEAR_BIT = 2;
    localparam int unsigned TC_MODE_HI   = 1;
    localparam int unsigned TC_MODE_LO   = 0;

    // flag bank bit positions
    localparam int unsigned FB_T1_EN_BIT  = 6;
    localparam int unsigned FB_T4_CH1_BIT = 5;
    localparam int unsigned FB_T4_CH0_BIT = 4;
    localparam int unsigned FB_T4_WRP_BIT = 3;
    localparam int unsigned FB_T3_CH1_BIT = 2;
    localparam int unsigned FB_T3_CH0_BIT = 1;
    localparam int unsigned FB_T3_WRP_BIT = 0;
    localparam int unsigned FB_FLAGS      = 6;

    // counting modes of timer 4
    typedef enum logic [1:0] {
        T4C_MODE_FREE   = 2'h_0,
        T4C_MODE_DOWN   = 2'h_1,
        T4C_MODE_MODULO = 2'h_2,
        T4C_MODE_UPDOWN = 2'h_3
    } t4c_count_mode_t;

    // edge selection codes
    localparam logic [1:0] EDGE_OFF     = 2'h_0;
    localparam logic [1:0] EDGE_RISE    = 2'h_1;
    localparam logic [1:0] EDGE_FALL    = 2'h_2;
    localparam logic [1:0] EDGE_BOTH    = 2'h_3;

    // match output action codes
    localparam logic [2:0] ACT_SET      = 3'h_0;
    localparam logic [2:0] ACT_CLEAR    = 3'h_1;
    localparam logic [2:0] ACT_TOGGLE   = 3'h_2;
    localparam logic [2:0] ACT_SET_UP   = 3'h_3;
    localparam logic [2:0] ACT_CLR_UP   = 3'h_4;
    localparam logic [2:0] ACT_SET_CH0  = 3'h_5;
    localparam logic [2:0] ACT_CLR_CH0  = 3'h_6;

    // channel 1 control layout
    typedef struct packed {
        logic       unused;
        logic       chan_irq_enable;
        logic [2:0] match_output_action;
        logic       compare_mode;
        logic [1:0] edge_sense_select;
    } t4c_chan1_ctrl_t;

    localparam t4c_chan1_ctrl_t CHAN1_CTRL_RESET = '{unused: 1'b0, chan_irq_enable: 1'b1,
        match_output_action: 3'h_0, compare_mode: 1'b0, edge_sense_select: 2'h_0};

    // pending flags of both 8-bit timers
    typedef struct packed {
        logic t4_chan1_pending;
        logic t4_chan0_pending;
        logic t4_wrap_pending;
        logic t3_chan1_pending;
        logic t3_chan0_pending;
        logic t3_wrap_pending;
    } t4c_flags_t;

endpackage : t4c_pkg

// *** rtl/t4c_sync.sv ***
// Purpose: two-stage synchroniser for one asynchronous level
// Assumes: destination clock is the block clock
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module t4c_sync (
    input  wire logic clk_i,
    input  wire logic rst_n,
    input  wire logic d_i,
    output logic      q_o
);

    logic meta;

    // two flops in series, nothing else reads meta
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule // t4c_sync

// *** rtl/t4c_top.sv ***
// Purpose: timer 4 counter, channel 1 capture/compare and shared timer flag bank
// Assumes: tick_i and timer 3 events come from logic on clk_i; cap_pin_i is asynchronous
// Notes:   read data appear one cycle after the read strobe
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module t4c_top (
    input  wire logic                        clk_i,
    input  wire logic                        rstn_i,
    input  wire logic [t4c_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [t4c_pkg::DATA_W-1:0]  wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [t4c_pkg::DATA_W-1:0]  rdata_o,
    input  wire logic                        tick_i,
    input  wire logic                        cap_pin_i,
    output logic                             cmp_pin_o,
    output logic                             cmp_pin_oe_o,
    input  wire logic                        t3_chan1_evt_i,
    input  wire logic                        t3_chan0_evt_i,
    input  wire logic                        t3_wrap_evt_i,
    output logic                             t1_wrap_irq_enable_o,
    output logic                             irq_o
);

    logic                     rst_meta;
    logic                     rst_n;
    logic                     cap_sync;
    logic                     cap_prev;
    logic [7:0]               count;
    logic                     count_up;
    logic                     run;
    t4c_pkg::t4c_count_mode_t mode;
    t4c_pkg::t4c_chan1_ctrl_t chan1_control;
    t4c_pkg::t4c_flags_t      flags;
    logic [5:0]               irq_mask;
    logic                     t1_wrap_irq_enable;
    logic [7:0]               chan0_match_value;
    logic [7:0]               chan1_match_value;
    logic                     step;
    logic                     at_top;
    logic                     at_zero;
    logic                     wrap_evt;
    logic                     own_match;
    logic                     ch0_match;
    logic                     zero_hit;
    logic                     rise_evt;
    logic                     fall_evt;
    logic                     cap_evt;
    logic                     ch1_evt;
    logic                     updown;
    logic                     clear_req;
    logic [7:0]               top_value;
    logic [7:0]               next_count;
    logic                     next_count_up;
    logic [7:0]               next_rdata;
    t4c_pkg::t4c_flags_t      set_vec;
    t4c_pkg::t4c_flags_t      keep_vec;
    t4c_pkg::t4c_flags_t      gate_vec;

    // reset release through two flops
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // capture pin enters the clock domain
    t4c_sync u_cap_sync (
        .clk_i (clk_i),
        .rst_n (rst_n),
        .d_i   (cap_pin_i),
        .q_o   (cap_sync)
    );

    // previous synchronised level for edge detection
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cap_prev <= 1'b0;
        end else begin
            cap_prev <= cap_sync;
        end
    end

    // edge selection for capture
    assign rise_evt = cap_sync & ~cap_prev;
    assign fall_evt = ~cap_sync & cap_prev;
    always_comb begin
        cap_evt = 1'b0;
        unique case (chan1_control.edge_sense_select)
            t4c_pkg::EDGE_OFF:  cap_evt = 1'b0;                 // R2
            t4c_pkg::EDGE_RISE: cap_evt = rise_evt;             // R2
            t4c_pkg::EDGE_FALL: cap_evt = fall_evt;             // R2
            t4c_pkg::EDGE_BOTH: cap_evt = rise_evt | fall_evt;  // R2
        endcase
        cap_evt = cap_evt & ~chan1_control.compare_mode;        // R1
    end

    // counter events, evaluated on each timer step
    assign step      = tick_i & run;
    assign updown    = (mode == t4c_pkg::T4C_MODE_UPDOWN);
    assign top_value = (mode == t4c_pkg::T4C_MODE_FREE) ? t4c_pkg::COUNT_FULL
                                                        : chan0_match_value; // R15
    assign at_top    = (count == top_value);
    assign at_zero   = (count == t4c_pkg::COUNT_ZERO);
    assign own_match = step & (count == chan1_match_value);
    assign ch0_match = step & (count == chan0_match_value);
    assign zero_hit  = step & at_zero;
    assign ch1_evt   = cap_evt | (own_match & chan1_control.compare_mode);  // R16

    // next counter value per counting mode
    always_comb begin
        next_count    = count;
        next_count_up = count_up;
        wrap_evt      = 1'b0;
        unique case (mode)
            t4c_pkg::T4C_MODE_FREE, t4c_pkg::T4C_MODE_MODULO: begin
                next_count_up = 1'b1;
                if (at_top) begin
                    next_count = t4c_pkg::COUNT_ZERO;           // R15
                    wrap_evt   = 1'b1;
                end else begin
                    next_count = count + t4c_pkg::COUNT_ONE;
                end
            end
            t4c_pkg::T4C_MODE_DOWN: begin
                next_count_up = 1'b0;
                if (at_zero) begin
                    next_count = chan0_match_value;
                    wrap_evt   = 1'b1;
                end else begin
                    next_count = count - t4c_pkg::COUNT_ONE;
                end
            end
            t4c_pkg::T4C_MODE_UPDOWN: begin
                if (count_up && at_top) begin
                    next_count_up = 1'b0;                       // R15
                    next_count    = at_zero ? count : count - t4c_pkg::COUNT_ONE;
                end else if (!count_up && at_zero) begin
                    next_count_up = 1'b1;                       // R15
                    next_count    = at_top ? count : count + t4c_pkg::COUNT_ONE;
                    wrap_evt      = 1'b1;
                end else if (count_up) begin
                    next_count    = count + t4c_pkg::COUNT_ONE;
                end else begin
                    next_count    = count - t4c_pkg::COUNT_ONE;
                end
            end
        endcase
        wrap_evt = wrap_evt & step;
    end

    // timer counter and direction
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            count    <= t4c_pkg::COUNT_ZERO;
            count_up <= 1'b1;
        end else if (clear_req) begin
            count    <= t4c_pkg::COUNT_ZERO;
            count_up <= 1'b1;
        end else if (step) begin
            count    <= next_count;
            count_up <= next_count_up;
        end
    end

    // timer control register, clear bit acts once and reads zero
    assign clear_req = wr_i & (addr_i == t4c_pkg::ADDR_TIMER_CTRL)
        & wdata_i[t4c_pkg::TC_CLEAR_BIT];
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            run  <= 1'b0;
            mode <= t4c_pkg::T4C_MODE_FREE;
        end else if (wr_i && addr_i == t4c_pkg::ADDR_TIMER_CTRL) begin
            run  <= wdata_i[t4c_pkg::TC_START_BIT];
            mode <= t4c_pkg::t4c_count_mode_t'(wdata_i[t4c_pkg::TC_MODE_HI:t4c_pkg::TC_MODE_LO]);
        end
    end

    // channel 1 control register
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            chan1_control <= t4c_pkg::CHAN1_CTRL_RESET;                 // R1 R8
        end else if (wr_i && addr_i == t4c_pkg::ADDR_CHAN1_CTRL) begin
            chan1_control        <= t4c_pkg::t4c_chan1_ctrl_t'(wdata_i);
            chan1_control.unused <= 1'b0;                               // R8
        end
    end

    // channel 0 value register
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            chan0_match_value <= t4c_pkg::VAL_RESET;                    // R9
        end else if (wr_i && addr_i == t4c_pkg::ADDR_CHAN0_VAL) begin
            chan0_match_value <= wdata_i;                               // R9
        end
    end

    // channel 1 value register, a capture overrides a same-cycle write
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            chan1_match_value <= t4c_pkg::VAL_RESET;                    // R10
        end else if (cap_evt) begin
            chan1_match_value <= count;                                 // R16
        end else if (wr_i && addr_i == t4c_pkg::ADDR_CHAN1_VAL) begin
            chan1_match_value <= wdata_i;                               // R10
        end
    end

    // compare output pin, own match has priority over the second event
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmp_pin_o <= 1'b0;
        end else if (chan1_control.compare_mode) begin
            unique case (chan1_control.match_output_action)
                t4c_pkg::ACT_SET: begin
                    if (own_match) cmp_pin_o <= 1'b1;                   // R3
                end
                t4c_pkg::ACT_CLEAR: begin
                    if (own_match) cmp_pin_o <= 1'b0;                   // R3
                end
                t4c_pkg::ACT_TOGGLE: begin
                    if (own_match) cmp_pin_o <= ~cmp_pin_o;             // R3
                end
                t4c_pkg::ACT_SET_UP: begin
                    if (own_match && (!updown || count_up)) begin
                        cmp_pin_o <= 1'b1;                              // R4
                    end else if (updown ? (own_match && !count_up) : zero_hit) begin
                        cmp_pin_o <= 1'b0;                              // R4
                    end
                end
                t4c_pkg::ACT_CLR_UP: begin
                    if (own_match && (!updown || count_up)) begin
                        cmp_pin_o <= 1'b0;                              // R5
                    end else if (updown ? (own_match && !count_up) : zero_hit) begin
                        cmp_pin_o <= 1'b1;                              // R5
                    end
                end
                t4c_pkg::ACT_SET_CH0: begin
                    if (own_match) begin
                        cmp_pin_o <= 1'b1;                              // R6
                    end else if (ch0_match) begin
                        cmp_pin_o <= 1'b0;                              // R6
                    end
                end
                t4c_pkg::ACT_CLR_CH0: begin
                    if (own_match) begin
                        cmp_pin_o <= 1'b0;                              // R7
                    end else if (ch0_match) begin
                        cmp_pin_o <= 1'b1;                              // R7
                    end
                end
                default: begin
                    cmp_pin_o <= cmp_pin_o;                             // R3
                end
            endcase
        end
    end

    // pin is driven only while channel 1 compares
    assign cmp_pin_oe_o = chan1_control.compare_mode;                   // R1

    // flag set and keep terms; a set wins over a same-cycle clear
    always_comb begin
        set_vec  = '{t4_chan1_pending: ch1_evt, t4_chan0_pending: ch0_match,
                     t4_wrap_pending: wrap_evt, t3_chan1_pending: t3_chan1_evt_i,
                     t3_chan0_pending: t3_chan0_evt_i, t3_wrap_pending: t3_wrap_evt_i};
        keep_vec = flags;
        if (wr_i && addr_i == t4c_pkg::ADDR_FLAG_BANK) begin
            keep_vec = flags
                & t4c_pkg::t4c_flags_t'(wdata_i[t4c_pkg::FB_FLAGS-1:0]); // R11 R12 R13
        end
    end

    // pending flags of the shared bank
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;                                                // R12
        end else begin
            flags <= set_vec | keep_vec;                                // R11 R12 R13 R16
        end
    end

    // timer 1 wrap enable in the shared bank
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            t1_wrap_irq_enable <= 1'b1;                                 // R14
        end else if (wr_i && addr_i == t4c_pkg::ADDR_FLAG_BANK) begin
            t1_wrap_irq_enable <= wdata_i[t4c_pkg::FB_T1_EN_BIT];       // R14
        end
    end
    assign t1_wrap_irq_enable_o = t1_wrap_irq_enable;

    // interrupt mask, same layout as the flag bits
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= t4c_pkg::MASK_RESET;
        end else if (wr_i && addr_i == t4c_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= wdata_i[t4c_pkg::FB_FLAGS-1:0];
        end
    end

    // one level interrupt from pending, enabled flags
    always_comb begin
        gate_vec = flags & t4c_pkg::t4c_flags_t'(irq_mask);
        gate_vec.t4_chan1_pending = gate_vec.t4_chan1_pending
            & chan1_control.chan_irq_enable;                            // R17
    end
    assign irq_o = |gate_vec;                                           // R17

    // read multiplexer, unmapped addresses read zero
    always_comb begin
        next_rdata = t4c_pkg::READ_ZERO;
        unique case (addr_i)
            t4c_pkg::ADDR_FLAG_BANK:  next_rdata = {1'b0, t1_wrap_irq_enable, flags}; // R14
            t4c_pkg::ADDR_CHAN0_VAL:  next_rdata = chan0_match_value;
            t4c_pkg::ADDR_CHAN1_CTRL: next_rdata = chan1_control;       // R8
            t4c_pkg::ADDR_CHAN1_VAL:  next_rdata = chan1_match_value;
            t4c_pkg::ADDR_COUNT:      next_rdata = count;
            t4c_pkg::ADDR_TIMER_CTRL: next_rdata = {3'h_0, run, 2'h_0, mode};
            t4c_pkg::ADDR_IRQ_MASK:   next_rdata = {2'h_0, irq_mask};
            default:                  next_rdata = t4c_pkg::READ_ZERO;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= t4c_pkg::READ_ZERO;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= t4c_pkg::READ_ZERO;
        end
    end

endmodule // t4c_top

// *** sim/t4c_pin_model.sv ***
// Purpose: far-side model of the capture input pin
// Assumes: the pin moves at any time against the block clock
// Notes:   a delay argument lets it answer promptly or slowly
`timescale 1ns/1ps
module t4c_pin_model (
    input  wire logic clk_i,
    output logic      cap_pin_o
);
    // pin idles low until an edge is asked for
    initial cap_pin_o = 1'b0;
    // wait some cycles, then move the pin between clock edges
    task automatic set_level(input logic lvl, input int dly);
        repeat (dly) @(posedge clk_i);
        #7;
        cap_pin_o = lvl;
    endtask
endmodule // t4c_pin_model

// *** sim/t4c_top_assertions.sv ***
// Purpose: port-level checks of the timer 4 channel block
// Assumes: single clock domain, active-low reset
// Notes:   bound to t4c_top below the module
`timescale 1ns/1ps
module t4c_top_checker (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] rdata_o,
    input  wire logic       tick_i,
    input  wire logic       cmp_pin_o,
    input  wire logic       cmp_pin_oe_o,
    input  wire logic       t3_chan1_evt_i,
    input  wire logic       t1_wrap_irq_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // register reads and writes
    property p_ctl_top; $past(rd_i) && $past(addr_i) == 8'h_ee |-> !rdata_o[7]; endproperty
    a_ctl_top: assert property (p_ctl_top) else $error("ctl bit7 set");
    property p_flag_top; $past(rd_i) && $past(addr_i) == 8'h_d8 |-> !rdata_o[7]; endproperty
    a_flag_top: assert property (p_flag_top) else $error("flag bit7 set");
    property p_ch0_rw;
        rd_i && addr_i == 8'h_ed && !$past(wr_i) && $past(wr_i, 2) && $past(addr_i, 2) == 8'h_ed
        |=> rdata_o == $past(wdata_i, 3);
    endproperty
    a_ch0_rw: assert property (p_ch0_rw) else $error("chan0 readback");
    property p_t3_flag;
        t3_chan1_evt_i ##1 !wr_i ##1 (rd_i && addr_i == 8'h_d8) |=> rdata_o[2];
    endproperty
    a_t3_flag: assert property (p_t3_flag) else $error("t3 flag lost");
    property p_t1_en; wr_i && addr_i == 8'h_d8 |=> t1_wrap_irq_enable_o == $past(wdata_i[6]); endproperty
    a_t1_en: assert property (p_t1_en) else $error("t1 enable");
    // output enable follows the mode bit
    property p_oe_wr; wr_i && addr_i == 8'h_ee |=> cmp_pin_oe_o == $past(wdata_i[2]); endproperty
    a_oe_wr: assert property (p_oe_wr) else $error("oe not mode");
    property p_oe_hold; $changed(cmp_pin_oe_o) |-> $past(wr_i) && $past(addr_i) == 8'h_ee; endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("oe moved");
    // compare output moves only on a timer step
    property p_pin_tick; $changed(cmp_pin_o) |-> $past(tick_i); endproperty
    a_pin_tick: assert property (p_pin_tick) else $error("pin moved");
    // main scenarios reached
    c_rd_ch1: cover property (rd_i && addr_i == 8'h_ef);
    c_pin: cover property ($changed(cmp_pin_o) && cmp_pin_oe_o);
    c_t3: cover property (t3_chan1_evt_i);
endmodule // t4c_top_checker
bind t4c_top t4c_top_checker u_t4c_top_checker (.clk_i(clk_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .tick_i(tick_i), .cmp_pin_o(cmp_pin_o), .cmp_pin_oe_o(cmp_pin_oe_o),
    .t3_chan1_evt_i(t3_chan1_evt_i), .t1_wrap_irq_enable_o(t1_wrap_irq_enable_o));

// *** sim/t4c_top_tb.sv ***
// Purpose: self-checking bench of the timer 4 channel block
// Assumes: 20 MHz clock, pin model drives the capture pin
// Notes:   each scenario task checks its own results
`timescale 1ns/1ps
module t4c_top_tb;
    logic       clk_i, rstn_i, wr_i, rd_i, tick_i, cap, pin, oe, t1_en, irq;
    logic [7:0] addr_i, wdata_i, rdata, c, f;
    logic [2:0] t3_evt;
    int         mismatches, n_checks;
    // pin levels at counts 7, 12 and 2 after wrap, per action code
    logic [2:0] exp_tab [8] = '{3'h_7, 3'h_0, 3'h_7, 3'h_6, 3'h_1, 3'h_4, 3'h_3, 3'h_7};
    t4c_top u_t4c_top (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .tick_i(tick_i), .cap_pin_i(cap),
        .cmp_pin_o(pin), .cmp_pin_oe_o(oe), .t3_chan1_evt_i(t3_evt[2]),
        .t3_chan0_evt_i(t3_evt[1]), .t3_wrap_evt_i(t3_evt[0]),
        .t1_wrap_irq_enable_o(t1_en), .irq_o(irq));
    t4c_pin_model u_t4c_pin_model (.clk_i(clk_i), .cap_pin_o(cap));
    // 50 ns clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    // one-cycle bus write and read
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(what, exp, d);
    endtask
    // n timer steps, then settle
    task automatic tick_n(input int n);
        @(posedge clk_i);
        tick_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        tick_i <= 1'b0;
        #1;
    endtask
    task automatic t_regs();
        rchk("flags", 8'h_d8, 8'h_40);
        rchk("ch0", 8'h_ed, 8'h_00);
        rchk("ctl", 8'h_ee, 8'h_40);
        rchk("ch1", 8'h_ef, 8'h_00);
        rchk("unmapped", 8'h_10, 8'h_00);
        wr(8'h_ed, 8'h_a5);
        rchk("ch0", 8'h_ed, 8'h_a5);
        wr(8'h_ef, 8'h_5a);
        rchk("ch1", 8'h_ef, 8'h_5a);
        wr(8'h_ee, 8'h_ff);
        rchk("ctl", 8'h_ee, 8'h_7f);
        chk("oe", 8'h_01, {7'h_00, oe});
        wr(8'h_ee, 8'h_40);
        wr(8'h_d8, 8'h_00);
        chk("t1 en", 8'h_00, {7'h_00, t1_en});
        wr(8'h_d8, 8'h_ff);
        rchk("flags", 8'h_d8, 8'h_40);
        $display("test regs done");
    endtask
    task automatic t_t3();
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            t3_evt <= 3'h_1 << i;
            @(posedge clk_i);
            t3_evt <= 3'h_0;
        end
        rchk("t3 flags", 8'h_d8, 8'h_47);
        chk("irq", 8'h_01, {7'h_00, irq});
        wr(8'h_e9, 8'h_00);
        chk("irq masked", 8'h_00, {7'h_00, irq});
        wr(8'h_d8, 8'h_40);
        rchk("t3 clear", 8'h_d8, 8'h_40);
        wr(8'h_e9, 8'h_3f);
        $display("test t3 done");
    endtask
    task automatic t_capture();
        wr(8'h_ed, 8'h_ff);
        wr(8'h_eb, 8'h_10);
        for (int k = 0; k < 4; k++) begin
            wr(8'h_ee, 8'h_40 | k[7:0]);
            for (int e = 1; e >= 0; e--) begin
                wr(8'h_d8, 8'h_40);
                tick_n(3);
                rd(8'h_ea, c);
                u_t4c_pin_model.set_level(e[0], k);
                repeat (6) @(posedge clk_i);
                #1;
                chk("cap irq", {7'h_00, k[1 - e]}, {7'h_00, irq});
                rd(8'h_d8, f);
                chk("cap flag", {7'h_00, k[1 - e]}, {7'h_00, f[5]});
                if (k[1 - e]) rchk("cap value", 8'h_ef, c);
            end
        end
        $display("test capture done");
    endtask
    task automatic t_compare();
        wr(8'h_ed, 8'h_0a);
        wr(8'h_ef, 8'h_05);
        for (int k = 0; k < 8; k++) begin
            wr(8'h_ee, 8'h_44 | (k[7:0] << 3));
            wr(8'h_eb, 8'h_14);
            tick_n(7);
            chk("pin 7", {7'h_00, exp_tab[k][2]}, {7'h_00, pin});
            tick_n(5);
            chk("pin 12", {7'h_00, exp_tab[k][1]}, {7'h_00, pin});
            tick_n(246);
            chk("pin wrap", {7'h_00, exp_tab[k][0]}, {7'h_00, pin});
        end
        rchk("flags", 8'h_d8, 8'h_78);
        chk("irq", 8'h_01, {7'h_00, irq});
        wr(8'h_d8, 8'h_40);
        rchk("flags", 8'h_d8, 8'h_40);
        $display("test compare done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rstn_i = 1'b0;
        {wr_i, rd_i, tick_i, t3_evt} = '0;
        {addr_i, wdata_i} = '0;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_regs();
        t_t3();
        t_capture();
        t_compare();
        close_out();
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        close_out();
    end
endmodule // t4c_top_tb
